/* pgp_pkg.sv */
package pgp_pkg;
    localparam int unsigned NUM_PINS      = 5;
    localparam logic [7:0] CMD_PIN_SET    = 8'h22;
    localparam logic [7:0] CMD_PIN_READ   = 8'h23;
    localparam logic [7:0] RSP_FLAG       = 8'h40;
    localparam logic [7:0] SET_LEN_VALUE  = 8'h02;
    localparam logic [7:0] SET_LEN_CONFIG = 8'h03;
    localparam logic [7:0] READ_LEN       = 8'h01;
    localparam logic [7:0] READ_RSP_LEN   = 8'h04;
    localparam logic [7:0] SET_RSP_LEN    = 8'h00;
    localparam logic [7:0] PWM_LAST_PHASE = 8'h63;
    localparam logic [3:0] CFG_FIELD_MASK = 4'hf;
    localparam int         CFG_FUNC_BIT   = 3;
    localparam logic [2:0] DRV_UP_PULLDN  = 3'h0;
    localparam logic [2:0] DRV_PUSH_FAST  = 3'h1;
    localparam logic [2:0] DRV_HIZ        = 3'h2;
    localparam logic [2:0] DRV_PULLUP_DN  = 3'h3;
    localparam logic [2:0] DRV_SLOW_UP    = 3'h4;
    localparam logic [2:0] DRV_PUSH_SLOW  = 3'h5;
    localparam logic [2:0] DRV_RESERVED   = 3'h6;
    localparam logic [2:0] DRV_SLOW_DN    = 3'h7;
    localparam logic [3:0] CFG_RST        = 4'h2;
    localparam logic [7:0] DUTY_RST       = 8'h00;
    localparam int         ST_LEVEL_BIT   = 0;
    localparam int         ST_FALL_BIT    = 1;
    localparam int         ST_RISE_BIT    = 2;
    localparam int         CLK_PERIOD_NS  = 40;
    localparam int         PWM_STEPS_N    = 100;
    localparam int         PWM_PERIOD_NS  = 10_000_000;
    localparam int         SAMPLE_PERIOD_NS = 31_250_000;
    localparam int         PWM_STEP_CYCLES = PWM_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS_N);
    localparam int         SAMPLE_CYCLES  = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int         STEP_CNT_W     = 12;
    localparam int         SAMPLE_CNT_W   = 20;
    localparam logic [7:0] REG_STATUS     = 8'h00;
    localparam logic [7:0] REG_MASK       = 8'h04;
    localparam logic [7:0] REG_LEVEL      = 8'h08;
    localparam int         STATUS_W       = 6;
    localparam int         STATUS_REJECT_BIT = 5;
    localparam logic [5:0] STATUS_RST     = 6'h00;
    localparam logic [5:0] MASK_RST       = 6'h00;
endpackage

/* pgp_pin_unit.sv */
`timescale 1ns/1ps
module pgp_pin_unit (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] duty,
    input  wire logic [3:0] cfg,
    input  wire logic [7:0] pwm_phase,
    input  wire logic       sample_tick,
    input  wire logic       pin_in,
    input  wire logic       alt_level,
    input  wire logic       flag_clear,
    output wire logic       level,
    output wire logic       rise,
    output wire logic       fall,
    output wire logic       edge_evt,
    output wire logic       drv_out,
    output wire logic       drv_oe,
    output wire logic       drv_pu,
    output wire logic       drv_pd,
    output wire logic       drv_slow
);
    import pgp_pkg::*;

    logic level_r;
    logic rise_r;
    logic fall_r;
    logic edge_r;
    logic out_r, oe_r, pu_r, pd_r, slow_r;
    logic out_nxt, oe_nxt, pu_nxt, pd_nxt, slow_nxt;

    // Phase runs 0..99, so duty 0 never drives high and duty 100 never drives low.
    wire logic pwm_level   = (duty > pwm_phase);
    wire logic drive_level = cfg[CFG_FUNC_BIT] ? pwm_level : alt_level;
    wire logic rise_now    = sample_tick & pin_in & ~level_r;
    wire logic fall_now    = sample_tick & ~pin_in & level_r;

    always_comb begin
        out_nxt  = drive_level;
        oe_nxt   = 1'b0;
        pu_nxt   = 1'b0;
        pd_nxt   = 1'b0;
        slow_nxt = 1'b0;
        case (cfg[2:0])
            DRV_UP_PULLDN: begin
                oe_nxt = drive_level;
                pd_nxt = ~drive_level;
            end
            DRV_PUSH_FAST: oe_nxt = 1'b1;
            DRV_PULLUP_DN: begin
                oe_nxt = ~drive_level;
                pu_nxt = drive_level;
            end
            DRV_SLOW_UP: begin
                oe_nxt   = drive_level;
                slow_nxt = 1'b1;
            end
            DRV_PUSH_SLOW: begin
                oe_nxt   = 1'b1;
                slow_nxt = 1'b1;
            end
            DRV_SLOW_DN: begin
                oe_nxt   = ~drive_level;
                slow_nxt = 1'b1;
            end
            // The reserved code is left floating, like plain input mode.
            default: oe_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= 1'b0;
            rise_r  <= 1'b0;
            fall_r  <= 1'b0;
            edge_r  <= 1'b0;
            out_r   <= 1'b0;
            oe_r    <= 1'b0;
            pu_r    <= 1'b0;
            pd_r    <= 1'b0;
            slow_r  <= 1'b0;
        end else begin
            if (sample_tick) begin
                level_r <= pin_in;
            end
            // A new edge in the clearing cycle survives the clear.
            rise_r <= rise_now | (rise_r & ~flag_clear);
            fall_r <= fall_now | (fall_r & ~flag_clear);
            edge_r <= rise_now | fall_now;
            out_r  <= out_nxt;
            oe_r   <= oe_nxt;
            pu_r   <= pu_nxt;
            pd_r   <= pd_nxt;
            slow_r <= slow_nxt;
        end
    end

    assign level    = level_r;
    assign rise     = rise_r;
    assign fall     = fall_r;
    assign edge_evt = edge_r;
    assign drv_out  = out_r;
    assign drv_oe   = oe_r;
    assign drv_pu   = pu_r;
    assign drv_pd   = pd_r;
    assign drv_slow = slow_r;
endmodule

/* pgp_gpio_port.sv */
// Function
// - Pin-set code 0x22; two payload bytes change only the pin's output level.
// - Three payload bytes also store the third byte as function and drive mode.
// - Level 0 drives low, 100 drives high; 101 to 255 are never sent.
// - Levels 1 to 99 give a 100 Hz PWM with that percent high time.
// - Drive mode codes select strong, slow, resistive or floating for each level.
// - Function bit 1 gives user control; 0 returns pin to shared function.
// - All pins are sampled at 32 Hz regardless of commands.
// - Sticky rise and fall flags per pin are cleared when reported.
// - Pin-read code 0x23 names one pin; the reply echoes that index first.
// - Second reply byte: level bit 0, falling bit 1, rising bit 2, rest zero.
// - Reported level is the sampled pin; pulses between samples are missed.
// - Third reply byte is the stored level, fourth the stored configuration.
// - Upper config bits in the read reply are always zero.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module pgp_gpio_port #(
    parameter int SAMPLE_CYCLES = pgp_pkg::SAMPLE_CYCLES
) (
    input  wire logic                               ref_clk,
    input  wire logic                               rst_n,
    input  wire logic                               cmd_valid,
    input  wire logic [7:0]                         cmd_type,
    input  wire logic [7:0]                         cmd_len,
    input  wire logic [7:0]                         cmd_data0,
    input  wire logic [7:0]                         cmd_data1,
    input  wire logic [7:0]                         cmd_data2,
    output wire logic                               rsp_valid,
    output wire logic [7:0]                         rsp_type,
    output wire logic [7:0]                         rsp_len,
    output wire logic [7:0]                         rsp_data0,
    output wire logic [7:0]                         rsp_data1,
    output wire logic [7:0]                         rsp_data2,
    output wire logic [7:0]                         rsp_data3,
    input  wire logic [pgp_pkg::NUM_PINS-1:0]       pin_in,
    input  wire logic [pgp_pkg::NUM_PINS-1:0]       alt_level,
    output wire logic [pgp_pkg::NUM_PINS-1:0]       pin_out,
    output wire logic [pgp_pkg::NUM_PINS-1:0]       pin_oe,
    output wire logic [pgp_pkg::NUM_PINS-1:0]       pin_pull_up,
    output wire logic [pgp_pkg::NUM_PINS-1:0]       pin_pull_down,
    output wire logic [pgp_pkg::NUM_PINS-1:0]       pin_slow,
    output wire logic [pgp_pkg::NUM_PINS-1:0]       pin_user_ctl,
    input  wire logic [7:0]                         reg_addr,
    input  wire logic [31:0]                        reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output wire logic [31:0]                        reg_rdata,
    output wire logic                               irq
);
    import pgp_pkg::*;

    localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);
    localparam logic [STEP_CNT_W-1:0]   STEP_LAST   = STEP_CNT_W'(PWM_STEP_CYCLES - 1);
    localparam logic [7:0]              PIN_COUNT   = 8'(NUM_PINS);

    // Stored per-pin settings.
    logic [7:0] duty_r [NUM_PINS];
    logic [3:0] cfg_r  [NUM_PINS];

    // Shared timebase.
    logic [STEP_CNT_W-1:0]   step_cnt_r;
    logic [7:0]              phase_r;
    logic [SAMPLE_CNT_W-1:0] sample_cnt_r;
    logic                    sample_tick_r;

    // Reply registers.
    logic       rsp_valid_r;
    logic [7:0] rsp_type_r;
    logic [7:0] rsp_len_r;
    logic [7:0] rsp_data0_r;
    logic [7:0] rsp_data1_r;
    logic [7:0] rsp_data2_r;
    logic [7:0] rsp_data3_r;

    // Register bus state.
    logic [STATUS_W-1:0] status_r;
    logic [STATUS_W-1:0] status_nxt;
    logic [STATUS_W-1:0] mask_r;
    logic [31:0]         rdata_r;
    logic                irq_r;

    // Per-pin results from the pin units.
    logic [NUM_PINS-1:0] level_w;
    logic [NUM_PINS-1:0] rise_w;
    logic [NUM_PINS-1:0] fall_w;
    logic [NUM_PINS-1:0] edge_w;
    logic [NUM_PINS-1:0] clear_w;

    // Command decode.
    wire logic       idx_ok     = (cmd_data0 < PIN_COUNT);
    wire logic [2:0] idx        = cmd_data0[2:0];
    wire logic       is_set     = cmd_valid && (cmd_type == CMD_PIN_SET);
    wire logic       is_read    = cmd_valid && (cmd_type == CMD_PIN_READ);
    wire logic       set_len_ok = (cmd_len == SET_LEN_VALUE) || (cmd_len == SET_LEN_CONFIG);
    wire logic       set_hit    = is_set && set_len_ok && idx_ok;
    wire logic       set_cfg    = set_hit && (cmd_len == SET_LEN_CONFIG);
    wire logic       read_hit   = is_read && (cmd_len == READ_LEN) && idx_ok;
    wire logic       reject     = (is_set && !set_hit) || (is_read && !read_hit);

    // Reply fields for a read, taken from the selected pin before its flags clear.
    wire logic       sel_level  = level_w[idx];
    wire logic       sel_rise   = rise_w[idx];
    wire logic       sel_fall   = fall_w[idx];
    wire logic [7:0] status_byte = {5'h00, sel_rise, sel_fall, sel_level};
    wire logic [7:0] cfg_byte    = {4'h0, cfg_r[idx] & CFG_FIELD_MASK};

    // Register bus decode.
    wire logic hit_status = (reg_addr == REG_STATUS);
    wire logic hit_mask   = (reg_addr == REG_MASK);
    wire logic hit_level  = (reg_addr == REG_LEVEL);
    wire logic wr_status  = reg_wr && hit_status;
    wire logic wr_mask    = reg_wr && hit_mask;
    wire logic [STATUS_W-1:0] status_set = {reject, edge_w};
    wire logic [31:0] rd_mux =
        hit_status ? {{(32-STATUS_W){1'b0}}, status_r} :
        hit_mask   ? {{(32-STATUS_W){1'b0}}, mask_r} :
        hit_level  ? {{(32-NUM_PINS){1'b0}}, level_w} :
                     32'h0000_0000;

    // Reported flags clear only on the pin that is read.
    assign clear_w = read_hit ? NUM_PINS'(1) << idx : '0;

    // A set arriving with the write-one clear wins, so no event is lost.
    assign status_nxt = status_set | (status_r & ~(wr_status ? reg_wdata[STATUS_W-1:0] : '0));

    // Step counter divides the clock into 1 percent PWM slices, 100 slices per period.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt_r <= '0;
            phase_r    <= 8'h00;
        end else if (step_cnt_r == STEP_LAST) begin
            step_cnt_r <= '0;
            phase_r    <= (phase_r == PWM_LAST_PHASE) ? 8'h00 : phase_r + 8'h01;
        end else begin
            step_cnt_r <= step_cnt_r + STEP_CNT_W'(1);
        end
    end

    // Sampling runs free; host traffic never delays or resynchronises it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_cnt_r  <= '0;
            sample_tick_r <= 1'b0;
        end else begin
            sample_tick_r <= (sample_cnt_r == SAMPLE_LAST);
            sample_cnt_r  <= (sample_cnt_r == SAMPLE_LAST) ? '0 :
                             sample_cnt_r + SAMPLE_CNT_W'(1);
        end
    end

    // Configuration storage; a two-byte set leaves the configuration untouched.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                duty_r[i] <= DUTY_RST;
                cfg_r[i]  <= CFG_RST;
            end
        end else begin
            if (set_hit) begin
                duty_r[idx] <= cmd_data1;
            end
            if (set_cfg) begin
                cfg_r[idx] <= cmd_data2[3:0] & CFG_FIELD_MASK;
            end
        end
    end

    // Replies come one cycle after the command; other codes get no reply here.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_type_r  <= 8'h00;
            rsp_len_r   <= 8'h00;
            rsp_data0_r <= 8'h00;
            rsp_data1_r <= 8'h00;
            rsp_data2_r <= 8'h00;
            rsp_data3_r <= 8'h00;
        end else begin
            rsp_valid_r <= set_hit || read_hit;
            if (set_hit) begin
                rsp_type_r  <= CMD_PIN_SET | RSP_FLAG;
                rsp_len_r   <= SET_RSP_LEN;
                rsp_data0_r <= 8'h00;
                rsp_data1_r <= 8'h00;
                rsp_data2_r <= 8'h00;
                rsp_data3_r <= 8'h00;
            end else if (read_hit) begin
                rsp_type_r  <= CMD_PIN_READ | RSP_FLAG;
                rsp_len_r   <= READ_RSP_LEN;
                rsp_data0_r <= cmd_data0;
                rsp_data1_r <= status_byte;
                rsp_data2_r <= duty_r[idx];
                rsp_data3_r <= cfg_byte;
            end
        end
    end

    // Status, mask and read data for the register port.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= STATUS_RST;
            mask_r   <= MASK_RST;
            rdata_r  <= 32'h0000_0000;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            if (wr_mask) begin
                mask_r <= reg_wdata[STATUS_W-1:0];
            end
            rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
            irq_r   <= |(status_nxt & (wr_mask ? reg_wdata[STATUS_W-1:0] : mask_r));
        end
    end

    // One pin unit per pin: PWM, drive decode and the sampled edge tracker.
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gen_pin
            pgp_pin_unit u_pin (
                .ref_clk     (ref_clk),
                .rst_n       (rst_n),
                .duty        (duty_r[g]),
                .cfg         (cfg_r[g]),
                .pwm_phase   (phase_r),
                .sample_tick (sample_tick_r),
                .pin_in      (pin_in[g]),
                .alt_level   (alt_level[g]),
                .flag_clear  (clear_w[g]),
                .level       (level_w[g]),
                .rise        (rise_w[g]),
                .fall        (fall_w[g]),
                .edge_evt    (edge_w[g]),
                .drv_out     (pin_out[g]),
                .drv_oe      (pin_oe[g]),
                .drv_pu      (pin_pull_up[g]),
                .drv_pd      (pin_pull_down[g]),
                .drv_slow    (pin_slow[g])
            );
            assign pin_user_ctl[g] = cfg_r[g][CFG_FUNC_BIT];
        end
    endgenerate

    assign rsp_valid = rsp_valid_r;
    assign rsp_type  = rsp_type_r;
    assign rsp_len   = rsp_len_r;
    assign rsp_data0 = rsp_data0_r;
    assign rsp_data1 = rsp_data1_r;
    assign rsp_data2 = rsp_data2_r;
    assign rsp_data3 = rsp_data3_r;
    assign reg_rdata = rdata_r;
    assign irq       = irq_r;
endmodule

/* pgp_gpio_port_sva.sv */
`timescale 1ns/1ps
module pgp_gpio_port_sva
    import pgp_pkg::*;
#(
    parameter int SAMPLE_CYCLES = 20
) (
    input wire logic                         ref_clk,
    input wire logic                         rst_n,
    input wire logic                         cmd_valid,
    input wire logic [7:0]                   cmd_type,
    input wire logic [7:0]                   cmd_len,
    input wire logic [7:0]                   cmd_data0,
    input wire logic [7:0]                   cmd_data2,
    input wire logic                         rsp_valid,
    input wire logic [7:0]                   rsp_type,
    input wire logic [7:0]                   rsp_len,
    input wire logic [7:0]                   rsp_data0,
    input wire logic [7:0]                   rsp_data1,
    input wire logic [7:0]                   rsp_data3,
    input wire logic [pgp_pkg::NUM_PINS-1:0] pin_user_ctl
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_set_ok;
        cmd_valid && cmd_type == CMD_PIN_SET && cmd_data0 < NUM_PINS
            && (cmd_len == SET_LEN_VALUE || cmd_len == SET_LEN_CONFIG);
    endsequence
    sequence s_read_ok;
        cmd_valid && cmd_type == CMD_PIN_READ && cmd_len == READ_LEN && cmd_data0 < NUM_PINS;
    endsequence
    a_set_reply: assert property (s_set_ok |=> rsp_valid && rsp_type == 8'h62
        && rsp_len == SET_RSP_LEN) else $error("Pin-set reply is wrong.");
    a_read_echo: assert property (s_read_ok |=> rsp_valid && rsp_type == 8'h63
        && rsp_len == READ_RSP_LEN && rsp_data0 == $past(cmd_data0))
        else $error("Pin-read reply is wrong.");
    a_reply_cause: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("Reply without a command.");
    a_reply_type: assert property (rsp_valid |-> rsp_type == ($past(cmd_type) | RSP_FLAG))
        else $error("Reply type does not match command.");
    a_bad_index: assert property (cmd_valid && cmd_data0 >= NUM_PINS
        && (cmd_type == CMD_PIN_SET || cmd_type == CMD_PIN_READ) |=> !rsp_valid)
        else $error("Reserved index was answered.");
    a_read_pads: assert property (rsp_valid && rsp_type == 8'h63 |->
        rsp_data1[7:3] == 5'h00 && rsp_data3[7:4] == 4'h0) else $error("Reply pad bits set.");
    a_func_bit: assert property (s_set_ok ##0 cmd_len == SET_LEN_CONFIG |=>
        pin_user_ctl[$past(cmd_data0[2:0])] == $past(cmd_data2[CFG_FUNC_BIT]))
        else $error("Function bit not applied.");
    a_value_only: assert property (s_set_ok ##0 cmd_len == SET_LEN_VALUE |=>
        $stable(pin_user_ctl)) else $error("Value-only set changed function.");
endmodule

/* pgp_host_model.sv */
`timescale 1ns/1ps
module pgp_host_model (
    input  wire logic ref_clk,
    output logic       cmd_valid,
    output logic [7:0] cmd_type,
    output logic [7:0] cmd_len,
    output logic [7:0] cmd_data0,
    output logic [7:0] cmd_data1,
    output logic [7:0] cmd_data2
);
    // Non-blocking here too, so every write to these outputs is of one kind.
    initial begin
        cmd_valid <= 1'b0;
        {cmd_type, cmd_len, cmd_data0, cmd_data1, cmd_data2} <= 40'h00_0000_0000;
    end
    // One packet per call; bytes are inverted afterwards so stale data never looks fresh.
    task automatic send(input logic [7:0] t, l, d0, d1, d2);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_type  <= t;
        cmd_len   <= l;
        cmd_data0 <= d0;
        cmd_data1 <= d1;
        cmd_data2 <= d2 & 8'h0f;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        {cmd_type, cmd_len, cmd_data0, cmd_data1, cmd_data2} <= ~{t, l, d0, d1, d2};
        #1;
    endtask
endmodule

/* tb_pgp_gpio_port.sv */
`timescale 1ns/1ps
module tb_pgp_gpio_port;
    import pgp_pkg::*;
    localparam int SMP = 20;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_valid, rsp_valid, irq;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  cmd_type, cmd_len, cmd_data0, cmd_data1, cmd_data2;
    logic [7:0]  rsp_type, rsp_len, rsp_data0, rsp_data1, rsp_data2, rsp_data3;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic [4:0]  pin_in = 5'h00;
    logic [4:0]  alt_level = 5'h00;
    logic [4:0]  pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_slow, pin_user_ctl;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #20 ref_clk = ~ref_clk;
    pgp_host_model pgp_host_model_inst (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
        .cmd_type(cmd_type), .cmd_len(cmd_len), .cmd_data0(cmd_data0),
        .cmd_data1(cmd_data1), .cmd_data2(cmd_data2));
    pgp_gpio_port #(.SAMPLE_CYCLES(SMP)) pgp_gpio_port_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_len(cmd_len), .cmd_data0(cmd_data0),
        .cmd_data1(cmd_data1), .cmd_data2(cmd_data2), .rsp_valid(rsp_valid),
        .rsp_type(rsp_type), .rsp_len(rsp_len), .rsp_data0(rsp_data0), .rsp_data1(rsp_data1),
        .rsp_data2(rsp_data2), .rsp_data3(rsp_data3), .pin_in(pin_in), .alt_level(alt_level),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
        .pin_pull_down(pin_pull_down), .pin_slow(pin_slow), .pin_user_ctl(pin_user_ctl),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic set_pin(input logic [7:0] idx, val, cfg, len);
        pgp_host_model_inst.send(CMD_PIN_SET, len, idx, val, cfg);
        check({rsp_valid, rsp_type, rsp_len}, {1'b1, 8'h62, 8'h00}, "set reply");
    endtask
    task automatic rd_pin(input logic [7:0] idx, st, val, cfg);
        pgp_host_model_inst.send(CMD_PIN_READ, READ_LEN, idx, 8'h00, 8'h00);
        check({rsp_valid, rsp_type, rsp_len, rsp_data0, rsp_data1, rsp_data2, rsp_data3},
            {1'b1, 8'h63, 8'h04, idx, st, val, cfg}, "read reply");
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e, "register read");
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Expected {oe, pull up, pull down, slow, out} for a drive code and logical level.
    function automatic logic [4:0] drv_exp(input logic [2:0] m, input logic l);
        case (m)
            3'h0: return {l, 1'b0, ~l, 1'b0, l};
            3'h1: return {1'b1, 3'b000, l};
            3'h3: return {~l, l, 2'b00, l};
            3'h4: return {l, 2'b00, 1'b1, l};
            3'h5: return {1'b1, 2'b00, 1'b1, l};
            3'h7: return {~l, 2'b00, 1'b1, l};
            default: return {4'h0, l};
        endcase
    endfunction
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_pin(8'd0, 8'h00, 8'h00, 8'h02);
        set_pin(8'd0, 8'd1, 8'h09, 8'd3);
        idle(2);
        check(pin_out[0], 1'b1, "duty one in first step");
        while (cyc < 2600) @(posedge ref_clk);
        #1;
        check(pin_out[0], 1'b0, "duty one after first step");
        set_pin(8'd0, 8'd100, 8'h04, 8'd2);
        rd_pin(8'd0, 8'h00, 8'd100, 8'h09);
        check({pin_out[0], pin_user_ctl[0]}, 2'b11, "forced high");
        set_pin(8'd0, 8'd0, 8'h04, 8'd2);
        idle(2);
        check(pin_out[0], 1'b0, "forced low");
        $display("Test value and duty done");
        // Function bit set, so the drive follows the programmed level, not the shared one.
        for (int m = 0; m < 8; m++) begin
            if (m == 6) continue;
            for (int l = 0; l < 2; l++) begin
                set_pin(8'd2, l ? 8'd100 : 8'd0, {5'h01, m[2:0]}, 8'd3);
                idle(2);
                check({pin_oe[2], pin_pull_up[2], pin_pull_down[2], pin_slow[2], pin_out[2]},
                    drv_exp(m[2:0], l[0]), "drive mode");
                rd_pin(8'd2, 8'h00, l ? 8'd100 : 8'd0, {5'h01, m[2:0]});
            end
        end
        $display("Test drive modes done");
        @(posedge ref_clk) alt_level <= 5'h10;
        set_pin(8'd4, 8'd0, 8'h01, 8'd3);
        idle(2);
        check({pin_user_ctl[4], pin_oe[4], pin_out[4]}, 3'b011, "shared function");
        $display("Test function select done");
        @(posedge ref_clk) pin_in <= 5'h08;
        idle(2 * SMP + 4);
        @(posedge ref_clk) pin_in <= 5'h00;
        idle(2 * SMP + 4);
        rd_pin(8'd3, 8'h06, 8'h00, 8'h02);
        rd_pin(8'd3, 8'h00, 8'h00, 8'h02);
        @(posedge ref_clk) pin_in <= 5'h08;
        idle(2 * SMP + 4);
        rd_pin(8'd3, 8'h05, 8'h00, 8'h02);
        rd_reg(REG_LEVEL, 32'h0000_0008);
        rd_reg(REG_STATUS, 32'h0000_0008);
        wr_reg(REG_STATUS, 32'h0000_003f);
        rd_reg(REG_STATUS, 32'h0000_0000);
        $display("Test input sampling done");
        pgp_host_model_inst.send(CMD_PIN_SET, 8'd3, 8'd5, 8'd0, 8'h01);
        check(rsp_valid, 1'b0, "reserved set index");
        pgp_host_model_inst.send(CMD_PIN_READ, 8'd1, 8'd255, 8'd0, 8'h00);
        check(rsp_valid, 1'b0, "reserved read index");
        pgp_host_model_inst.send(CMD_PIN_READ, 8'd2, 8'd1, 8'd0, 8'h00);
        check(rsp_valid, 1'b0, "bad read length");
        check(irq, 1'b0, "masked interrupt");
        wr_reg(REG_MASK, 32'h0000_0020);
        idle(1);
        check(irq, 1'b1, "interrupt raised");
        rd_reg(REG_STATUS, 32'h0000_0020);
        wr_reg(8'h0c, 32'hffff_ffff);
        rd_reg(8'h0c, 32'h0000_0000);
        rd_reg(REG_MASK, 32'h0000_0020);
        wr_reg(REG_STATUS, 32'h0000_0020);
        idle(1);
        check(irq, 1'b0, "interrupt cleared");
        $display("Test refusal and interrupt done");
        report_and_stop();
    end
endmodule
bind pgp_gpio_port pgp_gpio_port_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) pgp_gpio_port_sva_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
    .cmd_len(cmd_len), .cmd_data0(cmd_data0), .cmd_data2(cmd_data2), .rsp_valid(rsp_valid),
    .rsp_type(rsp_type), .rsp_len(rsp_len), .rsp_data0(rsp_data0), .rsp_data1(rsp_data1),
    .rsp_data3(rsp_data3), .pin_user_ctl(pin_user_ctl));
